// ---- pkg/rwl_pkg.sv ----
/*
 Constants, types and register map of the register write-lock gate.
 Assumes a single system bus clock and a 4 KB APB window for the system control block.
*/
package rwl_pkg;

  localparam int RWL_AW = 12;
  localparam int RWL_DW = 32;
  localparam int RWL_NREG = 7;

  // Byte offsets inside the system control window.
  localparam logic [11:0] OFS_KEY = 12'h100;
  localparam logic [11:0] OFS_RESET_CTL = 12'h008;
  localparam logic [11:0] OFS_BROWNOUT_CTL = 12'h018;
  localparam logic [11:0] OFS_POR_CTL = 12'h024;
  localparam logic [11:0] OFS_VREF_CTL = 12'h028;
  localparam logic [11:0] OFS_POWER_CTL = 12'h200;
  localparam logic [11:0] OFS_PCLK_EN = 12'h208;
  localparam logic [11:0] OFS_CLKSEL2 = 12'h214;

  // Positions of the guarded registers in the storage array.
  localparam int IDX_RESET_CTL = 0;
  localparam int IDX_BROWNOUT_CTL = 1;
  localparam int IDX_POR_CTL = 2;
  localparam int IDX_VREF_CTL = 3;
  localparam int IDX_POWER_CTL = 4;
  localparam int IDX_PCLK_EN = 5;
  localparam int IDX_CLKSEL2 = 6;

  localparam logic [11:0] REG_OFS [RWL_NREG] = '{OFS_RESET_CTL, OFS_BROWNOUT_CTL,
    OFS_POR_CTL, OFS_VREF_CTL, OFS_POWER_CTL, OFS_PCLK_EN, OFS_CLKSEL2};

  // A set bit is write-protected while the gate is locked.
  localparam logic [31:0] PROT_MASK_FULL = 32'hFFFF_FFFF;
  localparam logic [31:0] PROT_MASK_POWER = 32'hFFFF_FFBF;
  localparam logic [31:0] PROT_MASK_PCLK = 32'h0000_0001;
  localparam logic [31:0] PROT_MASK_CLKSEL2 = 32'h0000_0003;
  localparam logic [31:0] REG_PROT_MASK [RWL_NREG] = '{PROT_MASK_FULL, PROT_MASK_FULL,
    PROT_MASK_FULL, PROT_MASK_FULL, PROT_MASK_POWER, PROT_MASK_PCLK, PROT_MASK_CLKSEL2};

  localparam logic [31:0] REG_RESET_VAL = 32'h0000_0000;
  localparam logic [31:0] KEY_RESET_VAL = 32'h0000_0000;
  localparam int POWER_WAKE_CLR_BIT = 6;
  localparam int UNLOCK_BIT = 0;

  localparam logic [7:0] KEY_FIRST = 8'h59;
  localparam logic [7:0] KEY_SECOND = 8'h16;
  localparam logic [7:0] KEY_THIRD = 8'h88;

  typedef enum {
    KEY_WAIT_FIRST,
    KEY_WAIT_SECOND,
    KEY_WAIT_THIRD
  } rwl_key_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [RWL_AW-1:0] paddr;
    logic [RWL_DW-1:0] pwdata;
  } rwl_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [RWL_DW-1:0] prdata;
  } rwl_apb_rsp_t;

endpackage

// ---- core/rwl_gate.sv ----
/*
 Register write-lock gate: key register, unlock sequencer and the guarded system
 control registers, all behind one APB slave.
 Assumes APB requests on the same clock, and an external pulse for writes that the
 system bus makes to addresses outside this window.
*/
// Decided for this implementation: the APB register port.
// Operation
// - After reset the gate is locked and stays locked until a full key sequence is seen.
// - A wrong key byte, a write out of order or a write elsewhere cancels the attempt.
// - The third correct key write sets the unlock status and opens the guarded registers.
// - Bit 0 of the key register reads the unlock status, 1 meaning protection is off.
// - While unlocked, any write to the key register locks the gate again.
// - While locked, writes to the protected bits of guarded registers are dropped and those bits kept.
// - The key byte is write-only, reads give only the status, and the register resets to zero.
// - The reset, brown-out, power-on-reset and reference controls are guarded, and so are
//       flash, watchdog and PWM controls elsewhere through the unlock status output.
// - The wake-up interrupt clear bit 6 of the power control stays writable when locked.
// - Only bit 0 of the clock enable and bits 1 to 0 of the clock select are guarded.
`timescale 1ns/10ps
module rwl_gate #(
  parameter int NREG = rwl_pkg::RWL_NREG
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire rwl_pkg::rwl_apb_req_t i_apb_req,
  input wire logic i_ext_write,
  output rwl_pkg::rwl_apb_rsp_t o_apb_rsp,
  output logic o_unlock_status,
  output logic [NREG-1:0][rwl_pkg::RWL_DW-1:0] o_sys_regs
);
  import rwl_pkg::*;

  rwl_key_state_t key_state_ff;
  rwl_key_state_t nxt_key_state;
  logic unlock_ff;
  logic nxt_unlock;
  logic [RWL_DW-1:0] regs_ff [NREG];
  logic [NREG-1:0] reg_hit;
  logic key_hit;
  logic mapped;
  logic access_take;
  logic commit;
  logic wr_commit;
  logic key_write;
  logic other_write;
  logic [7:0] key_byte;
  logic [RWL_DW-1:0] rd_value;

  // Every transfer gets one wait state so that all answers come from flip-flops.
  assign access_take = i_apb_req.psel && i_apb_req.penable && !o_apb_rsp.pready;
  assign commit = i_apb_req.psel && i_apb_req.penable && o_apb_rsp.pready;
  assign wr_commit = commit && i_apb_req.pwrite;
  assign key_hit = (i_apb_req.paddr == OFS_KEY);
  assign mapped = key_hit || (|reg_hit);
  assign key_write = wr_commit && key_hit;
  assign key_byte = i_apb_req.pwdata[7:0];
  // A foreign write from the system bus counts the same as one to another offset here.
  assign other_write = (wr_commit && !key_hit) || i_ext_write;

  // Unlock sequencer.
  always_comb begin
    nxt_key_state = key_state_ff;
    nxt_unlock = unlock_ff;
    if (key_write && unlock_ff) begin
      nxt_unlock = 1'b0;
      nxt_key_state = KEY_WAIT_FIRST;
    end else if (key_write) begin
      case (key_state_ff)
        KEY_WAIT_FIRST: begin
          if (key_byte == KEY_FIRST) begin
            nxt_key_state = KEY_WAIT_SECOND;
          end
        end
        KEY_WAIT_SECOND: begin
          if (key_byte == KEY_SECOND) begin
            nxt_key_state = KEY_WAIT_THIRD;
          end else begin
            nxt_key_state = KEY_WAIT_FIRST;
          end
        end
        KEY_WAIT_THIRD: begin
          nxt_key_state = KEY_WAIT_FIRST;
          if (key_byte == KEY_THIRD) begin
            nxt_unlock = 1'b1;
          end
        end
        default: begin
          nxt_key_state = KEY_WAIT_FIRST;
        end
      endcase
    end else if (other_write) begin
      nxt_key_state = KEY_WAIT_FIRST;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      key_state_ff <= KEY_WAIT_FIRST;
    end else begin
      key_state_ff <= nxt_key_state;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      unlock_ff <= KEY_RESET_VAL[UNLOCK_BIT];
    end else begin
      unlock_ff <= nxt_unlock;
    end
  end

  // Flash, watchdog and PWM controls live in other blocks; they gate on this output.
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_unlock_status <= 1'b0;
    end else begin
      o_unlock_status <= nxt_unlock;
    end
  end

  // Guarded registers: decode, masked update and output per entry.
  for (genvar g = 0; g < NREG; g++) begin : g_reg
    logic [RWL_DW-1:0] nxt_reg;

    assign reg_hit[g] = (i_apb_req.paddr == REG_OFS[g]);

    always_comb begin
      nxt_reg = regs_ff[g];
      if (wr_commit && reg_hit[g]) begin
        if (unlock_ff) begin
          nxt_reg = i_apb_req.pwdata;
        end else begin
          // Locked: protected bits hold, the rest take the new data.
          nxt_reg = (regs_ff[g] & REG_PROT_MASK[g])
            | (i_apb_req.pwdata & ~REG_PROT_MASK[g]);
        end
      end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
        regs_ff[g] <= REG_RESET_VAL;
      end else begin
        regs_ff[g] <= nxt_reg;
      end
    end

    assign o_sys_regs[g] = regs_ff[g];
  end

  // Read data. The key byte itself is never returned.
  always_comb begin
    rd_value = '0;
    if (key_hit) begin
      rd_value[UNLOCK_BIT] = unlock_ff;
    end
    for (int i = 0; i < NREG; i++) begin
      if (reg_hit[i]) begin
        rd_value = regs_ff[i];
      end
    end
  end

  // APB answer. Unmapped offsets read zero and report a slave error; a write there is
  // still a write to another address and cancels a key sequence in progress.
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_apb_rsp <= '0;
    end else if (access_take) begin
      o_apb_rsp.pready <= 1'b1;
      o_apb_rsp.pslverr <= !mapped;
      o_apb_rsp.prdata <= i_apb_req.pwrite ? '0 : rd_value;
    end else begin
      o_apb_rsp <= '0;
    end
  end

  // Shadow tally of correct key bytes since the last break in the sequence. It is kept
  // apart from the sequencer so that the checks below do not echo its own decisions.
  logic [1:0] key_tally_ff;
  logic [1:0] nxt_key_tally;
  logic key_good;

  always_comb begin
    key_good = 1'b0;
    case (key_tally_ff)
      2'h0: key_good = (key_byte == KEY_FIRST);
      2'h1: key_good = (key_byte == KEY_SECOND);
      2'h2: key_good = (key_byte == KEY_THIRD);
      default: key_good = 1'b0;
    endcase
  end

  always_comb begin
    nxt_key_tally = key_tally_ff;
    if (key_write && (unlock_ff || !key_good)) begin
      nxt_key_tally = 2'h0;
    end else if (key_write) begin
      nxt_key_tally = key_tally_ff + 2'h1;
    end else if (other_write) begin
      nxt_key_tally = 2'h0;
    end
  end

  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      key_tally_ff <= 2'h0;
    end else begin
      key_tally_ff <= nxt_key_tally;
    end
  end

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);

  unlock_cause_a: assert property ($rose(unlock_ff) |->
      $past(key_write && key_state_ff == KEY_WAIT_THIRD && key_byte == KEY_THIRD))
    else $error("Unlock status rose without a third correct key write.");

  locked_hold_a: assert property (!unlock_ff && !key_write |=> !unlock_ff)
    else $error("Gate unlocked without a key write.");

  abort_seq_a: assert property (other_write && !key_write |=>
      key_state_ff == KEY_WAIT_FIRST)
    else $error("Key sequence survived a write to another address.");

  wrong_key_a: assert property (key_write && !unlock_ff
      && key_state_ff == KEY_WAIT_SECOND && key_byte != KEY_SECOND
      |=> key_state_ff == KEY_WAIT_FIRST && !unlock_ff)
    else $error("Wrong second key byte did not cancel the sequence.");

  restart_seq_a: assert property (key_write && !unlock_ff
      && key_state_ff == KEY_WAIT_FIRST && key_byte == KEY_FIRST
      |=> key_state_ff == KEY_WAIT_SECOND)
    else $error("First key byte not accepted after a cancelled sequence.");

  relock_a: assert property (key_write && unlock_ff |=> !unlock_ff ##1 !o_unlock_status)
    else $error("Key register write did not lock the gate.");

  status_read_a: assert property (access_take && key_hit && !i_apb_req.pwrite |=>
      o_apb_rsp.prdata == {31'h0000_0000, $past(unlock_ff)})
    else $error("Key register read did not return the unlock status.");

  key_hidden_a: assert property (access_take && key_hit |=>
      o_apb_rsp.prdata[31:1] == 31'h0000_0000)
    else $error("Key register read exposed bits above the status.");

  locked_drop_a: assert property (wr_commit && !unlock_ff
      && reg_hit[IDX_BROWNOUT_CTL]
      |=> regs_ff[IDX_BROWNOUT_CTL] == $past(regs_ff[IDX_BROWNOUT_CTL]))
    else $error("Locked write changed the brown-out control.");

  open_write_a: assert property (wr_commit && unlock_ff
      && reg_hit[IDX_VREF_CTL]
      |=> regs_ff[IDX_VREF_CTL] == $past(i_apb_req.pwdata))
    else $error("Unlocked write did not reach the reference control.");

  wake_clear_a: assert property (wr_commit && !unlock_ff
      && reg_hit[IDX_POWER_CTL]
      |=> regs_ff[IDX_POWER_CTL][POWER_WAKE_CLR_BIT] == $past(i_apb_req.pwdata[6])
      && regs_ff[IDX_POWER_CTL][5:0] == $past(regs_ff[IDX_POWER_CTL][5:0])
      && regs_ff[IDX_POWER_CTL][31:7] == $past(regs_ff[IDX_POWER_CTL][31:7]))
    else $error("Power control bit 6 not writable or other bits not held while locked.");

  pclk_mask_a: assert property (wr_commit && !unlock_ff && reg_hit[IDX_PCLK_EN] |=>
      regs_ff[IDX_PCLK_EN][0] == $past(regs_ff[IDX_PCLK_EN][0])
      && regs_ff[IDX_PCLK_EN][31:1] == $past(i_apb_req.pwdata[31:1]))
    else $error("Clock enable write ignored the bit 0 protection.");

  clksel_mask_a: assert property (wr_commit && !unlock_ff && reg_hit[IDX_CLKSEL2] |=>
      regs_ff[IDX_CLKSEL2][1:0] == $past(regs_ff[IDX_CLKSEL2][1:0])
      && regs_ff[IDX_CLKSEL2][31:2] == $past(i_apb_req.pwdata[31:2]))
    else $error("Clock select write ignored the bits 1 to 0 protection.");

  answer_time_a: assert property (access_take |=> o_apb_rsp.pready ##1 !o_apb_rsp.pready)
    else $error("Answer was not a single-cycle ready after one wait state.");

  status_mirror_a: assert property (o_unlock_status == unlock_ff)
    else $error("Unlock status output differs from the gate state.");

  first_wrong_a: assert property (key_write && !unlock_ff
      && key_state_ff == KEY_WAIT_FIRST && key_byte != KEY_FIRST
      |=> key_state_ff == KEY_WAIT_FIRST && !unlock_ff)
    else $error("Wrong first key byte moved the sequence on.");

  third_wrong_a: assert property (key_write && !unlock_ff
      && key_state_ff == KEY_WAIT_THIRD && key_byte != KEY_THIRD
      |=> key_state_ff == KEY_WAIT_FIRST && !unlock_ff)
    else $error("Wrong third key byte did not cancel the sequence.");

  second_key_a: assert property (key_write && !unlock_ff
      && key_state_ff == KEY_WAIT_SECOND && key_byte == KEY_SECOND
      |=> key_state_ff == KEY_WAIT_THIRD)
    else $error("Second key byte not accepted.");

  unlock_set_a: assert property (key_write && !unlock_ff
      && key_state_ff == KEY_WAIT_THIRD && key_byte == KEY_THIRD
      |=> unlock_ff && o_unlock_status)
    else $error("Third correct key byte did not unlock the gate.");

  relock_seq_a: assert property (key_write && unlock_ff |=>
      key_state_ff == KEY_WAIT_FIRST)
    else $error("A locking write started a new key sequence.");

  unlock_hold_a: assert property (unlock_ff && !key_write |=> unlock_ff)
    else $error("Gate locked again without a key register write.");

  ext_cancel_a: assert property (i_ext_write && !key_write |=>
      key_state_ff == KEY_WAIT_FIRST)
    else $error("Key sequence survived a write outside this window.");

  read_keeps_seq_a: assert property (commit && !i_apb_req.pwrite && !i_ext_write |=>
      key_state_ff == $past(key_state_ff))
    else $error("A register read disturbed the key sequence.");

  tally_unlock_a: assert property ($rose(unlock_ff) |-> key_tally_ff == 2'h3)
    else $error("Unlock without three correct key writes in a row.");

  tally_track_a: assert property (!unlock_ff |-> key_tally_ff != 2'h3
      && (key_tally_ff == 2'h0) == (key_state_ff == KEY_WAIT_FIRST)
      && (key_tally_ff == 2'h1) == (key_state_ff == KEY_WAIT_SECOND))
    else $error("Key sequencer lost step with the count of correct key writes.");

  slverr_map_a: assert property (access_take |=> o_apb_rsp.pslverr == !$past(mapped))
    else $error("Slave error did not match the address decode.");

  ready_pulse_a: assert property (o_apb_rsp.pready |=> !o_apb_rsp.pready)
    else $error("Ready stood for more than one cycle.");

  rsp_idle_a: assert property (!o_apb_rsp.pready |-> !o_apb_rsp.pslverr
      && o_apb_rsp.prdata == 32'h0000_0000)
    else $error("Response fields stood without ready.");

  write_rdata_a: assert property (access_take && i_apb_req.pwrite |=>
      o_apb_rsp.prdata == 32'h0000_0000)
    else $error("A write returned read data.");

  unmapped_zero_a: assert property (access_take && !mapped |=>
      o_apb_rsp.prdata == 32'h0000_0000)
    else $error("An unmapped read returned data.");

  // The same checks for every guarded entry, masked by its own protection pattern.
  for (genvar c = 0; c < NREG; c++) begin : g_reg_chk
    guard_bits_a: assert property (wr_commit && !unlock_ff && reg_hit[c] |=>
        (regs_ff[c] & REG_PROT_MASK[c]) == ($past(regs_ff[c]) & REG_PROT_MASK[c]))
      else $error("Locked write changed a guarded bit.");

    free_bits_a: assert property (wr_commit && !unlock_ff && reg_hit[c] |=>
        (regs_ff[c] & ~REG_PROT_MASK[c]) == ($past(i_apb_req.pwdata) & ~REG_PROT_MASK[c]))
      else $error("Locked write did not reach an unguarded bit.");

    open_store_a: assert property (wr_commit && unlock_ff && reg_hit[c] |=>
        regs_ff[c] == $past(i_apb_req.pwdata))
      else $error("Unlocked write did not reach a guarded register.");

    reg_quiet_a: assert property (!(wr_commit && reg_hit[c]) |=>
        regs_ff[c] == $past(regs_ff[c]))
      else $error("A guarded register changed without a write to it.");
  end

endmodule // rwl_gate

// ---- verification/tb_rwl_gate.sv ----
/*
 Self-checking bench for the register write-lock gate: APB master tasks, key sequences,
 locked and unlocked accesses to the guarded registers and a reset in mid-run.
 Assumes the one-wait-state APB slave and the i_ext_write pulse described for rwl_gate.
*/
`timescale 1ns/10ps
module tb_rwl_gate;
  import rwl_pkg::*;
  logic i_clock;
  logic i_reset_n;
  logic i_ext_write;
  rwl_apb_req_t req;
  rwl_apb_rsp_t rsp;
  logic st;
  logic [RWL_NREG-1:0][31:0] regs;
  int bad_count;
  int n_tests;
  int cyc;
  logic [31:0] rd;
  logic er;
  logic [31:0] mdl [7];
  logic [11:0] ofs [7] = '{12'h008, 12'h018, 12'h024, 12'h028, 12'h200, 12'h208, 12'h214};
  logic [31:0] pm [7] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
    32'hFFFF_FFBF, 32'h0000_0001, 32'h0000_0003};
  logic [31:0] bad_keys [7][3] = '{'{32'h58, 32'h16, 32'h88}, '{32'h59, 32'h17, 32'h88},
    '{32'h59, 32'h16, 32'h89}, '{32'h16, 32'h59, 32'h88}, '{32'h59, 32'h16, 32'h88},
    '{32'h59, 32'h16, 32'h88}, '{32'h59, 32'h16, 32'h88}};
  int bad_mode [7] = '{0, 0, 0, 0, 1, 2, 4};

  rwl_gate u_rwl_gate (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_apb_req(req),
    .i_ext_write(i_ext_write), .o_apb_rsp(rsp), .o_unlock_status(st), .o_sys_regs(regs));

  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask

  task automatic results();
    $display("mismatches=%0d comparisons=%0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // The request is held until the edge that samples pready, and read data is taken there.
  // Only the bench timeout ends a wait that never sees ready.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clock);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge i_clock);
    req.penable <= 1'b1;
    do begin
      @(posedge i_clock);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
    #1;
  endtask

  task automatic do_reset();
    @(posedge i_clock);
    i_reset_n <= 1'b0;
    repeat (20) @(posedge i_clock);
    i_reset_n <= 1'b1;
    foreach (mdl[i]) mdl[i] = 32'h0;
    #1;
  endtask

  task automatic chk_lock(input logic exp);
    chk1(st, exp);
    apb(1'b0, 12'h100, 32'h0);
    chk32(rd, {31'h0, exp});
  endtask

  // Mode 1 pulses an outside write, 2 writes a guarded register, 3 reads, 4 writes unmapped.
  task automatic keys(input logic [31:0] k0, k1, k2, input int mode);
    apb(1'b1, 12'h100, k0);
    if (mode == 1) begin
      @(posedge i_clock) i_ext_write <= 1'b1;
      @(posedge i_clock) i_ext_write <= 1'b0;
    end
    if (mode == 2) apb(1'b1, 12'h028, 32'h0);
    if (mode == 3) apb(1'b0, 12'h100, 32'h0);
    if (mode == 4) apb(1'b1, 12'h300, 32'h0);
    apb(1'b1, 12'h100, k1);
    apb(1'b1, 12'h100, k2);
  endtask

  task automatic pass_regs(input logic [31:0] w, input logic locked);
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, ofs[i], w ^ i);
      chk1(er, 1'b0);
      mdl[i] = locked ? ((mdl[i] & pm[i]) | ((w ^ i) & ~pm[i])) : (w ^ i);
      chk32(regs[i], mdl[i]);
      apb(1'b0, ofs[i], 32'h0);
      chk32(rd, mdl[i]);
    end
  endtask

  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
  end

  initial begin
    i_reset_n = 1'b0;
    i_ext_write = 1'b0;
    req = '0;
    bad_count = 0;
    n_tests = 0;
    cyc = 0;
    do_reset();
    chk_lock(1'b0);
    foreach (mdl[i]) chk32(regs[i], 32'h0);
    pass_regs(32'hFFFF_FFFF, 1'b1);
    apb(1'b0, 12'h300, 32'h0);
    chk1(er, 1'b1);
    chk32(rd, 32'h0);
    for (int j = 0; j < 7; j++) begin
      keys(bad_keys[j][0], bad_keys[j][1], bad_keys[j][2], bad_mode[j]);
      chk_lock(1'b0);
    end
    // Upper bits of a key write carry no meaning, so they are filled with noise here.
    keys(32'hA5A5_A559, 32'h5A5A_5A16, 32'hFFFF_FF88, 3);
    chk_lock(1'b1);
    pass_regs(32'h1234_5678, 1'b0);
    keys(32'h59, 32'h16, 32'h88, 0);
    chk_lock(1'b0);
    pass_regs(32'h0, 1'b1);
    keys(32'h59, 32'h16, 32'h88, 0);
    chk_lock(1'b1);
    do_reset();
    chk_lock(1'b0);
    foreach (mdl[i]) chk32(regs[i], 32'h0);
    results();
  end
endmodule // tb_rwl_gate
